// [rtl/reset_ctrl_pkg.sv]
// shared constants and types for the multi source reset controller
`default_nettype none
package reset_ctrl_pkg;
   // status bit positions, one per source
   localparam int STAT_POR = 0;
   localparam int STAT_HARD = 1;
   localparam int STAT_SOFT = 2;
   localparam int STAT_WDOG = 3;
   localparam int STAT_BMON = 4;
   localparam int STAT_HOST = 5;
   localparam int STAT_W = 6;
   localparam logic [STAT_W-1:0] STAT_RESET = 6'h01;
   // configuration widths
   localparam int HCW_W = 32;
   localparam int PORCFG_W = 16;
   localparam logic [HCW_W-1:0] HCW_RESET = 32'h0000_0000;
   localparam logic [PORCFG_W-1:0] PORCFG_RESET = 16'h0000;
   // hold times of the driven reset phase, in clock cycles
   localparam int HOLD_W = 8;
   localparam logic [HOLD_W-1:0] HARD_HOLD = 8'h10;
   localparam logic [HOLD_W-1:0] SOFT_HOLD = 8'h08;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_POR = 3'b001,
      ST_HARD = 3'b010,
      ST_SOFT = 3'b011,
      ST_RELEASE = 3'b100
   } rst_state_t;
endpackage
`default_nettype wire

// [rtl/reset_lines_if.sv]
// open-drain reset line signals shared between controller and pin stage
`timescale 1ns/1ns
`default_nettype none
interface reset_lines_if;
   logic hardIn;
   logic softIn;
   logic hardDrive;
   logic softDrive;
   modport ctrl (input hardIn, input softIn, output hardDrive, output softDrive);
   modport pins (output hardIn, output softIn, input hardDrive, input softDrive);
endinterface
`default_nettype wire

// [rtl/reset_pin_stage.sv]
// two-flop input synchronisers and open-drain drivers for reset lines
`timescale 1ns/1ns
`default_nettype none
module reset_pin_stage
   import reset_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic hardLineIn,
   input wire logic softLineIn,
   output logic hardLineOut,
   output logic hardLineOe,
   output logic softLineOut,
   output logic softLineOe,
   reset_lines_if.pins lines
);
   logic [1:0] hardSync_reg;
   logic [1:0] softSync_reg;
   // line levels are active low; idle level assumed released (high)
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         hardSync_reg <= 2'h3;
         softSync_reg <= 2'h3;
      end else begin
         hardSync_reg <= {hardSync_reg[0], hardLineIn};
         softSync_reg <= {softSync_reg[0], softLineIn};
      end
   end
   assign lines.hardIn = ~hardSync_reg[1];
   assign lines.softIn = ~softSync_reg[1];
   // open drain: only ever pull low, never drive high
   assign hardLineOut = 1'b0;
   assign softLineOut = 1'b0;
   assign hardLineOe = lines.hardDrive;
   assign softLineOe = lines.softDrive;
endmodule
`default_nettype wire

// [rtl/multi_source_reset_controller.sv]
// reset controller: gathers six reset sources and runs one of three flows: power-on, hard or soft
`timescale 1ns/1ns
`default_nettype none
module multi_source_reset_controller
   import reset_ctrl_pkg::*;
#(
   parameter logic [HOLD_W-1:0] HARD_CYCLES = HARD_HOLD,
   parameter logic [HOLD_W-1:0] SOFT_CYCLES = SOFT_HOLD
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic power_on_reset_in,
   input wire logic hardLineIn,
   output logic hardLineOut,
   output logic hardLineOe,
   input wire logic softLineIn,
   output logic softLineOut,
   output logic softLineOe,
   input wire logic wdogEnable,
   input wire logic wdogZero,
   input wire logic bmonEnable,
   input wire logic bmonZero,
   input wire logic hostResetCmd,
   input wire logic [PORCFG_W-1:0] porConfigIn,
   input wire logic [HCW_W-1:0] hardConfigWord,
   output logic systemPllReset,
   output logic coreReset,
   output logic logicReset,
   output logic [PORCFG_W-1:0] porConfig,
   output logic [HCW_W-1:0] hardConfig,
   output logic [STAT_W-1:0] resetStatus,
   output logic resetBusy
);
   reset_lines_if lines ();
   logic [1:0] porSync_reg;
   rst_state_t state_reg, state_next;
   logic [HOLD_W-1:0] count_reg;
   logic [STAT_W-1:0] pend_reg;
   logic driving;
   logic porReq, hardReq, softReq, extSoft;
   logic [STAT_W-1:0] events;

   reset_pin_stage pinStage (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .hardLineIn(hardLineIn),
      .softLineIn(softLineIn),
      .hardLineOut(hardLineOut),
      .hardLineOe(hardLineOe),
      .softLineOut(softLineOut),
      .softLineOe(softLineOe),
      .lines(lines)
   );

   // power-on pin is asynchronous to the core clock, so synchronise it
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         porSync_reg <= 2'h0;
      end else begin
         porSync_reg <= {porSync_reg[0], power_on_reset_in};
      end
   end

   assign driving = (state_reg != ST_IDLE);
   // our own drive reads back on the lines, so gate it out
   assign extSoft = lines.softIn & ~driving;
   // every source into one event vector
   always_comb begin
      events = '0;
      events[STAT_POR] = porSync_reg[1];
      events[STAT_HARD] = lines.hardIn & ~driving;
      events[STAT_SOFT] = extSoft;
      events[STAT_WDOG] = wdogEnable & wdogZero;
      events[STAT_BMON] = bmonEnable & bmonZero;
      events[STAT_HOST] = hostResetCmd;
   end
   assign porReq = events[STAT_POR];
   assign hardReq = events[STAT_HARD] | events[STAT_WDOG] | events[STAT_BMON];
   assign softReq = events[STAT_SOFT] | events[STAT_HOST];

   // flow selection; stronger request preempts a weaker running flow
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (porReq) begin
               state_next = ST_POR;
            end else if (hardReq) begin
               state_next = ST_HARD;
            end else if (softReq) begin
               state_next = ST_SOFT;
            end
         end
         ST_POR: begin
            if (!porReq && count_reg == '0) begin
               state_next = ST_RELEASE;
            end
         end
         ST_HARD: begin
            if (porReq) begin
               state_next = ST_POR;
            end else if (count_reg == '0) begin
               state_next = ST_RELEASE;
            end
         end
         ST_SOFT: begin
            if (porReq) begin
               state_next = ST_POR;
            end else if (hardReq) begin
               state_next = ST_HARD;
            end else if (count_reg == '0) begin
               state_next = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // an internal source firing in the tail must not be lost
            if (porReq) begin
               state_next = ST_POR;
            end else if (hardReq) begin
               state_next = ST_HARD;
            end else if (softReq) begin
               state_next = ST_SOFT;
            end else if (!lines.hardIn && !lines.softIn) begin
               // wait until the board lets go of the lines too
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg <= ST_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   // hold counter reloads on entry to each driven phase
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count_reg <= HARD_CYCLES;
      end else if (state_next != state_reg) begin
         count_reg <= (state_next == ST_SOFT) ? SOFT_CYCLES : HARD_CYCLES;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 8'h01;
      end
   end

   // causes gather during a flow and publish when it ends
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         // reset starts a power-on flow, so power-on is already a cause
         pend_reg <= STAT_RESET;
         resetStatus <= STAT_RESET;
      end else begin
         if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
            resetStatus <= pend_reg;
            pend_reg <= '0;
         end else if (state_reg == ST_IDLE && state_next == ST_IDLE) begin
            pend_reg <= '0;
         end else begin
            pend_reg <= pend_reg | events;
         end
      end
   end

   // power-on fields latch only while power-on reset is in force
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         porConfig <= PORCFG_RESET;
      end else if (state_reg == ST_POR) begin
         porConfig <= porConfigIn;
      end
   end

   // hard configuration word sampled in power-on and hard flows only
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         hardConfig <= HCW_RESET;
      end else if (state_reg == ST_POR || state_reg == ST_HARD) begin
         hardConfig <= hardConfigWord;
      end
   end

   // line drive: soft follows hard, both driven for power-on and hard
   always_comb begin
      lines.hardDrive = (state_reg == ST_POR) || (state_reg == ST_HARD);
      lines.softDrive = lines.hardDrive || (state_reg == ST_SOFT);
   end
   assign systemPllReset = (state_reg == ST_POR);
   assign logicReset = (state_reg == ST_POR);
   assign coreReset = driving;
   assign resetBusy = driving;

   // AST_ assertions
   sequence softRequestSeen;
      state_reg == ST_IDLE && softReq && !hardReq && !porReq;
   endsequence
   AST_SOFT_WITH_HARD: assert property (@(posedge core_clk) disable iff (!reset_n)
      hardLineOe |-> softLineOe)
      else $error("hard line driven without soft line");
   AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (!reset_n)
      hardLineOut == 1'b0 && softLineOut == 1'b0)
      else $error("reset line driven high");
   AST_POR_FLOW: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_reg == ST_POR |-> hardLineOe && softLineOe && systemPllReset && coreReset)
      else $error("power-on flow incomplete");
   AST_POR_CFG_ONLY: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(state_reg) != ST_POR |-> $stable(porConfig))
      else $error("power-on config changed outside power-on");
   AST_SOFT_KEEPS_CFG: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_reg == ST_SOFT |-> !hardLineOe && softLineOe ##1 $stable(hardConfig))
      else $error("soft flow disturbed config or hard line");
   AST_WDOG_HARD: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_reg == ST_IDLE && wdogEnable && wdogZero && !porReq |=> state_reg == ST_HARD)
      else $error("watchdog did not start hard flow");
   AST_BMON_HARD: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_reg == ST_IDLE && bmonEnable && bmonZero && !porReq |=> hardLineOe)
      else $error("bus monitor did not start hard flow");
   AST_SOFT_START: assert property (@(posedge core_clk) disable iff (!reset_n)
      softRequestSeen |=> state_reg == ST_SOFT ##1 coreReset)
      else $error("soft flow not started");
   AST_PRIORITY: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_reg == ST_IDLE && porReq |=> state_reg == ST_POR)
      else $error("power-on did not win");
   AST_STATUS: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_reg == ST_RELEASE && state_next == ST_IDLE |=> resetStatus == $past(pend_reg))
      else $error("status not published");
endmodule
`default_nettype wire

// [sim/board_reset_model.sv]
// board side of the two open-drain reset lines, pull-ups included
`timescale 1ns/1ns
`default_nettype none
module board_reset_model (
   input wire logic hardLineOe,
   input wire logic softLineOe,
   input wire logic boardHardPull,
   input wire logic boardSoftPull,
   output logic hardLine,
   output logic softLine
);
   // wired-and: any party pulls low, nobody ever drives high
   assign hardLine = !(hardLineOe || boardHardPull);
   assign softLine = !(softLineOe || boardSoftPull);
endmodule
`default_nettype wire

// [sim/multi_source_reset_controller_tb_top.sv]
// self-checking bench for the multi source reset controller
`timescale 1ns/1ns
`default_nettype none
module multi_source_reset_controller_tb_top
   import reset_ctrl_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic porIn = 1'b0, hardPull = 1'b0, softPull = 1'b0, hostResetCmd = 1'b0;
   logic wdogEnable = 1'b1, wdogZero = 1'b0, bmonEnable = 1'b1, bmonZero = 1'b0;
   logic [PORCFG_W-1:0] porConfigIn = 16'h5a3c;
   logic [HCW_W-1:0] hardConfigWord = 32'h1234abcd;
   logic hardLine, softLine, hardLineOut, hardLineOe, softLineOut, softLineOe;
   logic systemPllReset, coreReset, logicReset, resetBusy;
   logic [PORCFG_W-1:0] porConfig;
   logic [HCW_W-1:0] hardConfig;
   logic [STAT_W-1:0] resetStatus;
   int errorCnt = 0, checked = 0, cycles = 0;
   // 8 ns period
   always #4 core_clk = ~core_clk;
   board_reset_model i_board (.hardLineOe(hardLineOe), .softLineOe(softLineOe),
      .boardHardPull(hardPull), .boardSoftPull(softPull), .hardLine(hardLine),
      .softLine(softLine));
   // longer hard hold leaves room to pull the soft line mid-flow
   multi_source_reset_controller #(.HARD_CYCLES(8'h06), .SOFT_CYCLES(8'h02)) i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .power_on_reset_in(porIn),
      .hardLineIn(hardLine), .hardLineOut(hardLineOut), .hardLineOe(hardLineOe),
      .softLineIn(softLine), .softLineOut(softLineOut), .softLineOe(softLineOe),
      .wdogEnable(wdogEnable), .wdogZero(wdogZero), .bmonEnable(bmonEnable),
      .bmonZero(bmonZero), .hostResetCmd(hostResetCmd), .porConfigIn(porConfigIn),
      .hardConfigWord(hardConfigWord), .systemPllReset(systemPllReset),
      .coreReset(coreReset), .logicReset(logicReset), .porConfig(porConfig),
      .hardConfig(hardConfig), .resetStatus(resetStatus), .resetBusy(resetBusy));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, errorCnt);
      if (errorCnt == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bit order of the mask follows the status bits
   task automatic pulse(input logic [5:0] m, input int cyc);
      @(posedge core_clk);
      {hostResetCmd, bmonZero, wdogZero, softPull, hardPull, porIn} <= m;
      repeat (cyc) @(posedge core_clk);
      {hostResetCmd, bmonZero, wdogZero, softPull, hardPull, porIn} <= 6'h00;
   endtask
   // follow one flow to idle, noting which outputs were ever driven
   task automatic flow(input logic [5:0] st, input logic eh, input logic es,
      input logic ep);
      int n;
      logic sh, ss, sp, sl, sc, bad;
      n = 0;
      sh = 1'b0;
      ss = 1'b0;
      sp = 1'b0;
      sl = 1'b0;
      sc = 1'b0;
      bad = 1'b0;
      while (resetBusy !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      check(resetBusy, 1'b1);
      n = 0;
      while (resetBusy === 1'b1 && n < 200) begin
         sh |= hardLineOe;
         ss |= softLineOe;
         sp |= systemPllReset;
         sl |= logicReset;
         sc |= coreReset;
         if (hardLineOe === 1'b1 && softLineOe !== 1'b1) bad = 1'b1;
         if (hardLineOut !== 1'b0 || softLineOut !== 1'b0) bad = 1'b1;
         @(negedge core_clk);
         n++;
      end
      check(resetBusy, 1'b0);
      check(bad, 1'b0);
      check({sh, ss, sp, sl, sc}, {eh, es, ep, ep, 1'b1});
      check(resetStatus, st);
   endtask
   task automatic t_por();
      flow(6'h01, 1'b1, 1'b1, 1'b1);
      check(porConfig, 16'h5a3c);
      @(posedge core_clk);
      porConfigIn <= 16'h0f0f;
      pulse(6'h01, 2);
      flow(6'h01, 1'b1, 1'b1, 1'b1);
      check(porConfig, 16'h0f0f);
      $display("test por done");
   endtask
   task automatic t_internal();
      @(posedge core_clk);
      porConfigIn <= 16'hffff;
      hardConfigWord <= 32'hcafe0001;
      pulse(6'h08, 1);
      flow(6'h08, 1'b1, 1'b1, 1'b0);
      check(hardConfig, 32'hcafe0001);
      @(posedge core_clk);
      hardConfigWord <= 32'h0bad0002;
      pulse(6'h10, 1);
      flow(6'h10, 1'b1, 1'b1, 1'b0);
      check({porConfig, hardConfig}, {16'h0f0f, 32'h0bad0002});
      // a zero count with the source disabled must stay silent
      @(posedge core_clk);
      wdogEnable <= 1'b0;
      bmonEnable <= 1'b0;
      pulse(6'h18, 1);
      repeat (10) @(negedge core_clk);
      check(resetBusy, 1'b0);
      $display("test internal done");
   endtask
   task automatic t_external();
      @(posedge core_clk);
      hardConfigWord <= 32'h00c0ffee;
      pulse(6'h02, 2);
      flow(6'h02, 1'b1, 1'b1, 1'b0);
      check(hardConfig, 32'h00c0ffee);
      @(posedge core_clk);
      hardConfigWord <= 32'h11111111;
      pulse(6'h04, 2);
      flow(6'h04, 1'b0, 1'b1, 1'b0);
      check({porConfig, hardConfig}, {16'h0f0f, 32'h00c0ffee});
      pulse(6'h20, 1);
      flow(6'h20, 1'b0, 1'b1, 1'b0);
      $display("test external done");
   endtask
   task automatic t_mixed();
      @(posedge core_clk);
      wdogEnable <= 1'b1;
      pulse(6'h28, 1);
      flow(6'h28, 1'b1, 1'b1, 1'b0);
      pulse(6'h21, 2);
      flow(6'h21, 1'b1, 1'b1, 1'b1);
      // soft pulled by the board while the device drives: not a cause
      pulse(6'h08, 1);
      repeat (2) @(posedge core_clk);
      pulse(6'h04, 1);
      flow(6'h08, 1'b1, 1'b1, 1'b0);
      $display("test mixed done");
   endtask
   // hang guard, far above the roughly 150 cycles needed
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errorCnt++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      t_por();
      t_internal();
      t_external();
      t_mixed();
      stop_test();
   end
endmodule
`default_nettype wire
